// *** common/fnd_defs.vh ***
`ifndef FND_DEFS_VH
`define FND_DEFS_VH
`define FND_WORD_BITS 24
`define FND_ADDR_FREQ 2'h0
`define FND_ADDR_OPTIONS 2'h1
`define FND_ADDR_FIXED2 2'h2
`define FND_FREQ_RXTX 23
`define FND_FREQ_BAND 19
`define FND_PCNT_HI 18
`define FND_PCNT_LO 15
`define FND_SWAL_HI 14
`define FND_SWAL_LO 12
`define FND_FRAC_HI 11
`define FND_FRAC_LO 2
`define FND_OPT_DEFSEL 23
`define FND_OPT_FIXED_HI 22
`define FND_OPT_FIXED_LO 7
`define FND_OPT_FIXED 16'h2502
`define FND_OPT_LOCKEN 6
`define FND_OPT_LVL_HI 5
`define FND_OPT_LVL_LO 4
`define FND_OPT_REF_HI 3
`define FND_OPT_REF_LO 2
`define FND_FREQ_RESET 24'h000000
`define FND_OPT_RESET 24'h928109
`define FND_FIXED2_RESET 24'hC87806
`define FND_PRESC_HIGH 4'h8
`define FND_PRESC_LOW 4'h4
`define FND_DEN_RX0 10'h1F8
`define FND_DEN_RX1 10'h240
`define FND_DEN_RX3 10'h208
`define FND_DEN_TL0 10'h276
`define FND_DEN_TL1 10'h2D0
`define FND_DEN_TL3 10'h28A
`define FND_DEN_TH0 10'h237
`define FND_DEN_TH1 10'h288
`define FND_DEN_TH3 10'h249
`endif

// *** src/fnd_divider_config.v ***
`timescale 1ns/100ps
`include "fnd_defs.vh"

// Summary of operation
// - Integer divide is P times programmable plus swallow; P is 8 or 4.
// - Reference divider is 1 for select codes 00/01 and 2 for 10/11.
// - Receive mode denominators are 504, 576, 504, 520.
// - Transmit low band denominators are 630, 720, 630, 650.
// - Transmit high band denominators are 567, 648, 567, 585.
// - Latched word with address 01 loads the options register.
// - Default select bit is only passed out; outputs always decode the programmed words.
// - Lock pin shows filtered lock when enabled, else held low.
// - Two-bit output level picks one of four buffer power steps.
// - Reference select decodes 12.6, 14.4, 25.2, 26.0 MHz.
// - Latched word with address 10 loads fixed register two.
// - 24 bits shift MSB first on rising clock; latch rise commits.
// - Address 00 loads the frequency register with mode and counters.
// - Receive/transmit bit with band select chooses the denominator.
module fnd_divider_config #(
   parameter FILT_LEN = 4
) (
   input wire ref_clk,
   input wire arst_n,
   input wire linkClk,
   input wire linkData,
   input wire latchEnable,
   input wire lockRaw,
   output reg [3:0] prescaler,
   output reg [3:0] programmableCount,
   output reg [2:0] swallowCount,
   output reg [9:0] fractionNumerator,
   output reg [9:0] fractionDenominator,
   output reg [1:0] refDivider,
   output reg [1:0] refFreqSelect,
   output reg [3:0] outputLevel,
   output reg txMode,
   output reg bandSelect,
   output reg defaultSelect,
   output reg lockDetectEnable,
   output reg lockPin,
   output reg [23:0] fixedTwo,
   output reg [23:0] optionsWord,
   output reg [23:0] freqWord
);

   // =====================================================
   // Input synchronisers
   // =====================================================
   // Three stages; a change counts once stages two and three agree.
   reg [2:0] clkSync_reg;
   reg [2:0] datSync_reg;
   reg [2:0] leSync_reg;
   reg [2:0] lockSync_reg;
   reg clkLvl_reg;
   reg datLvl_reg;
   reg leLvl_reg;
   reg lockLvl_reg;

   always @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         clkSync_reg <= 3'h0;
         clkLvl_reg <= 1'b0;
      end else begin
         clkSync_reg <= {clkSync_reg[1:0], linkClk};
         if (clkSync_reg[1] == clkSync_reg[2]) begin
            clkLvl_reg <= clkSync_reg[2];
         end
      end
   end

   always @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         datSync_reg <= 3'h0;
         datLvl_reg <= 1'b0;
      end else begin
         datSync_reg <= {datSync_reg[1:0], linkData};
         if (datSync_reg[1] == datSync_reg[2]) begin
            datLvl_reg <= datSync_reg[2];
         end
      end
   end

   always @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         leSync_reg <= 3'h0;
         leLvl_reg <= 1'b0;
      end else begin
         leSync_reg <= {leSync_reg[1:0], latchEnable};
         if (leSync_reg[1] == leSync_reg[2]) begin
            leLvl_reg <= leSync_reg[2];
         end
      end
   end

   always @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         lockSync_reg <= 3'h0;
         lockLvl_reg <= 1'b0;
      end else begin
         lockSync_reg <= {lockSync_reg[1:0], lockRaw};
         if (lockSync_reg[1] == lockSync_reg[2]) begin
            lockLvl_reg <= lockSync_reg[2];
         end
      end
   end

   wire clkRise = (clkSync_reg[1] == clkSync_reg[2]) && clkSync_reg[2] && !clkLvl_reg;
   wire leRise = (leSync_reg[1] == leSync_reg[2]) && leSync_reg[2] && !leLvl_reg;
   // Data passes the same stages as the clock, so sample its agreed copy, else the held level.
   wire datNow = (datSync_reg[1] == datSync_reg[2]) ? datSync_reg[2] : datLvl_reg;

   // =====================================================
   // Shift register and word commit
   // =====================================================
   reg [23:0] shift_reg;

   always @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         shift_reg <= 24'h000000;
      end else if (clkRise) begin
         shift_reg <= {shift_reg[22:0], datNow};
      end
   end

   always @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         freqWord <= `FND_FREQ_RESET;
         optionsWord <= `FND_OPT_RESET;
         fixedTwo <= `FND_FIXED2_RESET;
      end else if (leRise) begin
         case (shift_reg[1:0])
            `FND_ADDR_FREQ: begin
               freqWord <= shift_reg;
            end
            `FND_ADDR_OPTIONS: begin
               optionsWord <= shift_reg;
            end
            `FND_ADDR_FIXED2: begin
               fixedTwo <= shift_reg;
            end
            default: begin
               freqWord <= freqWord;
            end
         endcase
      end
   end

   // =====================================================
   // Decode functions
   // =====================================================
   // denominator lookup
   function [9:0] denLookup;
      input tx;
      input band;
      input [1:0] sel;
      begin
         if (!tx) begin
            case (sel)
               2'h1: denLookup = `FND_DEN_RX1;
               2'h3: denLookup = `FND_DEN_RX3;
               default: denLookup = `FND_DEN_RX0;
            endcase
         end else if (!band) begin
            case (sel)
               2'h1: denLookup = `FND_DEN_TL1;
               2'h3: denLookup = `FND_DEN_TL3;
               default: denLookup = `FND_DEN_TL0;
            endcase
         end else begin
            case (sel)
               2'h1: denLookup = `FND_DEN_TH1;
               2'h3: denLookup = `FND_DEN_TH3;
               default: denLookup = `FND_DEN_TH0;
            endcase
         end
      end
   endfunction

   // =====================================================
   // Lock filter
   // =====================================================
   // A short run of agreeing samples rejects lock chatter during settling.
   reg [7:0] lockCnt_reg;
   reg lockFilt_reg;
   reg [7:0] lockCnt_next;
   reg lockFilt_next;

   always @* begin
      lockCnt_next = lockCnt_reg + 8'h01;
      lockFilt_next = lockFilt_reg;
      if (lockLvl_reg == lockFilt_reg) begin
         lockCnt_next = 8'h00;
      end else if (lockCnt_reg == FILT_LEN[7:0]) begin
         lockFilt_next = lockLvl_reg;
         lockCnt_next = 8'h00;
      end
   end

   always @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         lockCnt_reg <= 8'h00;
         lockFilt_reg <= 1'b0;
      end else begin
         lockCnt_reg <= lockCnt_next;
         lockFilt_reg <= lockFilt_next;
      end
   end

   // =====================================================
   // Output decode
   // =====================================================
   // options field layout
   wire defSel = optionsWord[`FND_OPT_DEFSEL];
   wire ldEn = optionsWord[`FND_OPT_LOCKEN];
   wire [1:0] lvl = optionsWord[`FND_OPT_LVL_HI:`FND_OPT_LVL_LO];
   wire [1:0] rsel = optionsWord[`FND_OPT_REF_HI:`FND_OPT_REF_LO];
   wire tx = freqWord[`FND_FREQ_RXTX];
   wire band = freqWord[`FND_FREQ_BAND];

   // =====================================================
   // Next output values
   // =====================================================
   // All decode sits here so that every decoded output flop sees one clean next value; the word registers load straight from the shift register.
   reg [3:0] prescaler_next;
   reg [3:0] programmableCount_next;
   reg [2:0] swallowCount_next;
   reg [9:0] fractionNumerator_next;
   reg [9:0] fractionDenominator_next;
   reg [1:0] refDivider_next;
   reg [1:0] refFreqSelect_next;
   reg [3:0] outputLevel_next;
   reg txMode_next;
   reg bandSelect_next;
   reg defaultSelect_next;
   reg lockDetectEnable_next;
   reg lockPin_next;

   always @* begin
      prescaler_next = band ? `FND_PRESC_HIGH : `FND_PRESC_LOW;
      programmableCount_next = freqWord[`FND_PCNT_HI:`FND_PCNT_LO];
      swallowCount_next = freqWord[`FND_SWAL_HI:`FND_SWAL_LO];
      fractionNumerator_next = freqWord[`FND_FRAC_HI:`FND_FRAC_LO];
      txMode_next = tx;
      bandSelect_next = band;

      // mode and band pick the denominator
      fractionDenominator_next = denLookup(tx, band, rsel);

      refDivider_next = rsel[1] ? 2'h2 : 2'h1;
      refFreqSelect_next = rsel;

      outputLevel_next = 4'h1 << lvl;
      defaultSelect_next = defSel;
      lockDetectEnable_next = ldEn;

      // lock pin gating
      // The pin stays grounded while disabled, whatever the filter holds.
      lockPin_next = ldEn & lockFilt_reg;
   end

   always @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         prescaler <= `FND_PRESC_LOW;
         programmableCount <= 4'h0;
         swallowCount <= 3'h0;
         fractionNumerator <= 10'h000;
         fractionDenominator <= `FND_DEN_RX0;
         refDivider <= 2'h1;
         refFreqSelect <= 2'h0;
         outputLevel <= 4'h1;
         txMode <= 1'b0;
         bandSelect <= 1'b0;
         defaultSelect <= 1'b1;
         lockDetectEnable <= 1'b0;
         lockPin <= 1'b0;
      end else begin
         prescaler <= prescaler_next;
         programmableCount <= programmableCount_next;
         swallowCount <= swallowCount_next;
         fractionNumerator <= fractionNumerator_next;
         fractionDenominator <= fractionDenominator_next;
         refDivider <= refDivider_next;
         refFreqSelect <= refFreqSelect_next;
         outputLevel <= outputLevel_next;
         txMode <= txMode_next;
         bandSelect <= bandSelect_next;
         defaultSelect <= defaultSelect_next;
         lockDetectEnable <= lockDetectEnable_next;
         lockPin <= lockPin_next;
      end
   end

endmodule

// *** dv/fnd_divider_config_properties.sv ***
`timescale 1ns/100ps
// ====================================
// Checker of the decoded outputs.
module fnd_divider_config_properties #(
   parameter FILT_LEN = 4
) (
   input wire ref_clk,
   input wire arst_n,
   input wire latchEnable,
   input wire [3:0] prescaler,
   input wire [9:0] fractionDenominator,
   input wire [1:0] refDivider,
   input wire [1:0] refFreqSelect,
   input wire [3:0] outputLevel,
   input wire txMode,
   input wire bandSelect,
   input wire lockDetectEnable,
   input wire lockPin,
   input wire [23:0] fixedTwo,
   input wire [23:0] optionsWord,
   input wire [23:0] freqWord
);
   wire [1:0] s = refFreqSelect;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!arst_n);
   property p_presc; prescaler == (bandSelect ? 4'h8 : 4'h4); endproperty
   a_presc: assert property (p_presc) else $error("prescaler wrong");
   property p_rdiv; refDivider == (s[1] ? 2'h2 : 2'h1); endproperty
   a_rdiv: assert property (p_rdiv) else $error("ref divider wrong");
   property p_rx; !txMode |-> fractionDenominator == (s == 2'h1 ? 10'h240 : s == 2'h3 ? 10'h208 : 10'h1F8);
   endproperty
   a_rx: assert property (p_rx) else $error("receive denominator wrong");
   property p_tl; txMode && !bandSelect |-> fractionDenominator == (s == 2'h1 ? 10'h2D0 : s == 2'h3 ? 10'h28A : 10'h276);
   endproperty
   a_tl: assert property (p_tl) else $error("low band denominator wrong");
   property p_th; txMode && bandSelect |-> fractionDenominator == (s == 2'h1 ? 10'h288 : s == 2'h3 ? 10'h249 : 10'h237);
   endproperty
   a_th: assert property (p_th) else $error("high band denominator wrong");
   // A word register may change only a few cycles after a latch rise, and only for its own address.
   property p_opt; !$stable(optionsWord) |-> optionsWord[1:0] == 2'h1 && $past(latchEnable, 3); endproperty
   a_opt: assert property (p_opt) else $error("options word changed wrongly");
   property p_two; !$stable(fixedTwo) |-> fixedTwo[1:0] == 2'h2 && $past(latchEnable, 3); endproperty
   a_two: assert property (p_two) else $error("fixed word changed wrongly");
   property p_freq; !$stable(freqWord) |-> freqWord[1:0] == 2'h0 && $past(latchEnable, 3); endproperty
   a_freq: assert property (p_freq) else $error("frequency word changed wrongly");
   property p_lock; !lockDetectEnable |-> !lockPin; endproperty
   a_lock: assert property (p_lock) else $error("lock pin not grounded");
   property p_lvl; outputLevel == (4'h1 << $past(optionsWord[5:4])); endproperty
   a_lvl: assert property (p_lvl) else $error("output level wrong");
endmodule
bind fnd_divider_config fnd_divider_config_properties #(.FILT_LEN(FILT_LEN)) u_props (.*);

// *** dv/fnd_host_model.sv ***
`timescale 1ns/100ps
// ====================================
// Host side of the serial link.
module fnd_host_model (
   output logic linkClk,
   output logic linkData,
   output logic latchEnable
);
   initial begin
      linkClk = 1'b0;
      linkData = 1'b0;
      latchEnable = 1'b0;
   end
   task automatic send(input logic [23:0] w);
      for (int i = 23; i >= 0; i--) begin
         linkData = w[i];
         #40 linkClk = 1'b1;
         #40 linkClk = 1'b0;
      end
      // The released data line must not keep showing the last bit.
      linkData = ~linkData;
      #40 latchEnable = 1'b1;
      #160 latchEnable = 1'b0;
      #40;
   endtask
endmodule

// *** dv/test_fnd_divider_config.sv ***
`timescale 1ns/100ps
`include "fnd_defs.vh"
module test_fnd_divider_config;
   logic ref_clk, arst_n, lockRaw;
   wire linkClk, linkData, latchEnable, txMode, bandSelect, defaultSelect, lockDetectEnable, lockPin;
   wire [3:0] prescaler, programmableCount, outputLevel;
   wire [2:0] swallowCount;
   wire [9:0] fractionNumerator, fractionDenominator;
   wire [1:0] refDivider, refFreqSelect;
   wire [23:0] fixedTwo, optionsWord, freqWord;
   integer err_count = 0, cmp_count = 0, cyc = 0, seed = 32'hC1162495, lim;
   logic [23:0] w, o;
   logic [3:0] b;
   logic [2:0] a;
   logic [9:0] n, d;
   fnd_divider_config #(.FILT_LEN(1)) dut (.*);
   fnd_host_model host (.*);
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_count++;
         conclude;
      end
   end
   function logic [9:0] den(input logic t, input logic bb, input logic [1:0] s);
      case ({t, t & bb})
         2'b00: den = s == 2'h1 ? 10'h240 : s == 2'h3 ? 10'h208 : 10'h1F8;
         2'b10: den = s == 2'h1 ? 10'h2D0 : s == 2'h3 ? 10'h28A : 10'h276;
         default: den = s == 2'h1 ? 10'h288 : s == 2'h3 ? 10'h249 : 10'h237;
      endcase
   endfunction
   task chk(input logic [23:0] got, input logic [23:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task put(input logic [23:0] x);
      @(negedge ref_clk);
      host.send(x);
   endtask
   task conclude;
      $display("compares %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   initial begin
      arst_n = 1'b0;
      lockRaw = 1'b0;
      repeat (3) @(posedge ref_clk);
      @(negedge ref_clk) arst_n = 1'b1;
      @(negedge ref_clk);
      chk(freqWord | fixedTwo ^ `FND_FIXED2_RESET, 24'h0);
      chk(optionsWord, `FND_OPT_RESET);
      chk(24'(refDivider), 24'h2);
      $display("reset test done");
      for (int i = 0; i < 16; i++) begin
         o = {i != 5, 16'h2502, i[0], i[3:2], i[1:0], 2'h1};
         d = den(i[3], i[2], i[1:0]);
         b = 4'h2 + 4'($unsigned($random(seed)) % 14);
         lim = i[2] ? 8 : 4;
         if (b < lim) lim = b;
         a = 3'($unsigned($random(seed)) % lim);
         n = i == 15 ? d - 10'h1 : 10'($unsigned($random(seed)) % d);
         w = {i[3], 3'h0, i[2], b, a, n, 2'h0};
         put(o);
         put(w);
         chk(optionsWord, o);
         chk(freqWord, w);
         chk(24'(prescaler), i[2] ? 24'h8 : 24'h4);
         chk(24'({programmableCount, swallowCount, fractionNumerator}), 24'({b, a, n}));
         chk(24'(fractionDenominator), 24'(d));
         chk(24'(refDivider), i[1] ? 24'h2 : 24'h1);
         chk(24'({refFreqSelect, outputLevel, txMode, bandSelect, defaultSelect, lockDetectEnable}),
             24'({i[1:0], 4'h1 << i[3:2], i[3], i[2], o[23], i[0]}));
      end
      $display("divide test done");
      w = {24'($random(seed)) & 24'hFFFFFC} | 24'h2;
      put(w);
      put(w | 24'h3);
      chk(fixedTwo, w);
      chk(optionsWord, o);
      $display("address test done");
      lockRaw = 1'b1;
      repeat (20) @(negedge ref_clk);
      chk(24'(lockPin), 24'h1);
      put(o & 24'hFFFFBF);
      chk(24'(lockPin), 24'h0);
      $display("lock test done");
      @(negedge ref_clk) arst_n = 1'b0;
      @(negedge ref_clk);
      chk(freqWord, `FND_FREQ_RESET);
      arst_n = 1'b1;
      conclude;
   end
endmodule
